// *** hw/asr_status_regs.sv ***
`include "asr_consts.svh"

// Notes on behaviour
// - Upper id nibble: fixed revision code, may differ across revisions.
// - Lower id nibble gives channel count: 0010 two, 0100 four channels.
// - Second id byte always reads zero.
// - No-operation command returns the general fault byte as status.
// - Unknown command ignored, sets bit 6; transfer clears unless held.
// - When locked, commands other than lock/unlock/nop/multi-read set bit 6.
// - Bit 5 set while serial fault register nonzero; cleared by reading it.
// - Bit 4 set on any threshold flag; clears once both input bytes read.
// - Bit 3 set on watchdog expiry; clears after general byte read back.
// - Bit 2 set on resynchronisation event resetting the signal path.
// - Bit 1 set on data overrun; transfer clears it unless persisting.
// - Bit 0 set on uncorrectable hamming or CRC input fault.
// - Check flag clears on serial register transfer unless persisting.
// - Positive fault register holds per-channel flags in bits 3 to 0.
// - Two-channel variant reads channel 3 and 4 flags as zero.
// - Negative fault register flags each channel over its threshold.
// - Reserved status bits always read zero.
// - Negative flags ch4..ch1 at bits 3..0, reset zero.
module asr_status_regs #(
  parameter int          NUM_CH   = 4,
  parameter logic [3:0]  REV_CODE = `ASR_REV_CODE  // Arbitrary value
) (
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic       rd_stb,
  input  wire logic [4:0] rd_addr,
  input  wire logic       wr_stb,
  input  wire logic [4:0] wr_addr,
  input  wire logic [7:0] wr_data,
  input  wire logic       cmd_stb,
  input  wire asr_pkg::asr_cmd_t cmd_kind,
  input  wire logic       if_locked,
  input  wire logic [2:0] serial_fault_bits,
  input  wire logic       watchdog_expired,
  input  wire logic       resync_event,
  input  wire logic       data_overrun,
  input  wire logic       input_check_error,
  input  wire logic [3:0] pos_over_threshold,
  input  wire logic [3:0] neg_over_threshold,
  output logic      [7:0] rd_data_r,
  output logic            rd_valid_r,
  output logic      [7:0] status_resp_r,
  output logic            status_resp_valid_r
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] rd_data;
    logic       rd_valid;
    logic [7:0] resp;
    logic       resp_valid;
    logic       pos_read;
    logic       neg_read;
    logic [3:0] pos;
    logic [3:0] neg;
  } asr_state_t;

  asr_state_t st_r;
  asr_state_t st_nxt;

  logic [3:0] ch_mask;
  logic [3:0] ch_code;
  logic       gen_xfer;
  logic       ser_xfer;
  logic       invalid_set;
  logic       bad_cmd;
  logic       locked_bad;
  logic       inp_set;
  logic       inp_clr;
  logic [6:0] flags;
  logic [7:0] gen_byte;

  assign ch_mask = (NUM_CH == 2) ? 4'h3 : 4'hf;
  assign ch_code = (NUM_CH == 2) ? `ASR_CH_CODE_TWO
                                 : `ASR_CH_CODE_FOUR;

  // Transfer of the general register: nop response or direct read
  assign gen_xfer = (cmd_stb && cmd_kind == asr_pkg::ASR_CMD_NOP) ||
                    (rd_stb && rd_addr == `ASR_ADDR_GEN_FAULT);
  assign ser_xfer = rd_stb && rd_addr == `ASR_ADDR_SER_FAULT;

  assign bad_cmd    = cmd_stb && cmd_kind == asr_pkg::ASR_CMD_BAD;
  assign locked_bad = cmd_stb && if_locked &&
                      cmd_kind == asr_pkg::ASR_CMD_OTHER;
  assign invalid_set = bad_cmd || locked_bad;

  assign inp_set = |((pos_over_threshold | neg_over_threshold) & ch_mask);
  assign inp_clr = st_r.pos_read && st_r.neg_read;

  // ----------------------------------------------------------------
  // Sticky flags, one per general fault bit below the reserved bit
  // ----------------------------------------------------------------
  asr_flag u_invalid (
    .ref_clk (ref_clk), .rst_b (rst_b),
    .set_in  (invalid_set), .clr_in (gen_xfer),
    .flag_r  (flags[`ASR_BIT_INVALID_CMD])
  );
  // Serial summary only drops when its source register is read
  asr_flag u_serial (
    .ref_clk (ref_clk), .rst_b (rst_b),
    .set_in  (|serial_fault_bits), .clr_in (ser_xfer),
    .flag_r  (flags[`ASR_BIT_SERIAL])
  );
  asr_flag u_inpsum (
    .ref_clk (ref_clk), .rst_b (rst_b),
    .set_in  (inp_set), .clr_in (inp_clr),
    .flag_r  (flags[`ASR_BIT_INPUT_SUM])
  );
  asr_flag u_wdog (
    .ref_clk (ref_clk), .rst_b (rst_b),
    .set_in  (watchdog_expired), .clr_in (gen_xfer),
    .flag_r  (flags[`ASR_BIT_WATCHDOG])
  );
  asr_flag u_resync (
    .ref_clk (ref_clk), .rst_b (rst_b),
    .set_in  (resync_event), .clr_in (gen_xfer),
    .flag_r  (flags[`ASR_BIT_RESYNC])
  );
  asr_flag u_overrun (
    .ref_clk (ref_clk), .rst_b (rst_b),
    .set_in  (data_overrun), .clr_in (gen_xfer),
    .flag_r  (flags[`ASR_BIT_OVERRUN])
  );
  // Check fault clears on the serial register transfer, not the general
  asr_flag u_check (
    .ref_clk (ref_clk), .rst_b (rst_b),
    .set_in  (input_check_error), .clr_in (ser_xfer),
    .flag_r  (flags[`ASR_BIT_INPUT_CHECK])
  );

  assign gen_byte = {1'b0, flags};

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.rd_valid   = 1'b0;
    st_nxt.resp_valid = 1'b0;
    // Live comparator state, masked for the narrow variant
    st_nxt.pos = pos_over_threshold & ch_mask;
    st_nxt.neg = neg_over_threshold & ch_mask;
    if (inp_clr) begin
      st_nxt.pos_read = 1'b0;
      st_nxt.neg_read = 1'b0;
    end
    if (rd_stb) begin
      st_nxt.rd_valid = 1'b1;
      case (rd_addr)
        `ASR_ADDR_ID_HIGH:   st_nxt.rd_data = {REV_CODE, ch_code};
        `ASR_ADDR_ID_LOW:    st_nxt.rd_data = `ASR_RESET_BYTE;
        `ASR_ADDR_GEN_FAULT: st_nxt.rd_data = gen_byte;
        `ASR_ADDR_POS_FAULT: begin
          st_nxt.rd_data  = {4'h0, st_r.pos};
          st_nxt.pos_read = 1'b1;
        end
        `ASR_ADDR_NEG_FAULT: begin
          st_nxt.rd_data  = {4'h0, st_r.neg};
          st_nxt.neg_read = 1'b1;
        end
        default:             st_nxt.rd_data = `ASR_RESET_BYTE;
      endcase
    end
    // A write strobe has no path into any register here
    if (cmd_stb && cmd_kind == asr_pkg::ASR_CMD_NOP) begin
      st_nxt.resp       = gen_byte;
      st_nxt.resp_valid = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rd_data_r           = st_r.rd_data;
  assign rd_valid_r          = st_r.rd_valid;
  assign status_resp_r       = st_r.resp;
  assign status_resp_valid_r = st_r.resp_valid;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_nop_resp;
    @(posedge ref_clk) disable iff (!rst_b)
      cmd_stb && cmd_kind == asr_pkg::ASR_CMD_NOP |=>
        status_resp_valid_r && status_resp_r == $past(gen_byte);
  endproperty
  a_nop_resp: assert property (p_nop_resp)
    else $error("nop response does not carry general fault byte");

  property p_invalid_set;
    @(posedge ref_clk) disable iff (!rst_b)
      invalid_set |=> flags[`ASR_BIT_INVALID_CMD];
  endproperty
  a_invalid_set: assert property (p_invalid_set)
    else $error("invalid command flag not set");

  property p_locked;
    @(posedge ref_clk) disable iff (!rst_b)
      cmd_stb && if_locked && cmd_kind == asr_pkg::ASR_CMD_OTHER |=>
        flags[`ASR_BIT_INVALID_CMD];
  endproperty
  a_locked: assert property (p_locked)
    else $error("locked command did not flag");

  property p_serial_clr;
    @(posedge ref_clk) disable iff (!rst_b)
      ser_xfer && !(|serial_fault_bits) |=> !flags[`ASR_BIT_SERIAL];
  endproperty
  a_serial_clr: assert property (p_serial_clr)
    else $error("serial summary not cleared by read");

  property p_wdog;
    @(posedge ref_clk) disable iff (!rst_b)
      watchdog_expired |=> flags[`ASR_BIT_WATCHDOG];
  endproperty
  a_wdog: assert property (p_wdog)
    else $error("watchdog flag not set");

  property p_overrun_clr;
    @(posedge ref_clk) disable iff (!rst_b)
      gen_xfer && !data_overrun |=> !flags[`ASR_BIT_OVERRUN];
  endproperty
  a_overrun_clr: assert property (p_overrun_clr)
    else $error("overrun flag not auto-cleared");

  property p_check_keep;
    @(posedge ref_clk) disable iff (!rst_b)
      flags[`ASR_BIT_INPUT_CHECK] && !ser_xfer |=>
        flags[`ASR_BIT_INPUT_CHECK];
  endproperty
  a_check_keep: assert property (p_check_keep)
    else $error("input check flag lost without transfer");

  property p_id_read;
    @(posedge ref_clk) disable iff (!rst_b)
      rd_stb && rd_addr == `ASR_ADDR_ID_HIGH |=>
        rd_valid_r && rd_data_r[3:0] == ch_code;
  endproperty
  a_id_read: assert property (p_id_read)
    else $error("channel count code wrong");

  property p_reserved;
    @(posedge ref_clk) disable iff (!rst_b)
      rd_valid_r |-> (rd_data_r[7:4] == 4'h0 ||
                      $past(rd_addr) == `ASR_ADDR_ID_HIGH ||
                      ($past(rd_addr) == `ASR_ADDR_GEN_FAULT &&
                       !rd_data_r[7]));
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved bits not zero");

  property p_narrow;
    @(posedge ref_clk) disable iff (!rst_b)
      NUM_CH == 2 |-> st_r.pos[3:2] == 2'b00 && st_r.neg[3:2] == 2'b00;
  endproperty
  a_narrow: assert property (p_narrow)
    else $error("absent channel flag set");

  property p_ro;
    @(posedge ref_clk) disable iff (!rst_b)
      wr_stb && !rd_stb && !cmd_stb |=> !status_resp_valid_r;
  endproperty
  a_ro: assert property (p_ro)
    else $error("write produced a response");

  // ----------------------------------------------------------------
  // Response, flag and read path checks
  // ----------------------------------------------------------------
  sequence s_nop_taken;
    cmd_stb && cmd_kind == asr_pkg::ASR_CMD_NOP;
  endsequence

  sequence s_lone_nop;
    s_nop_taken ##1 !cmd_stb;
  endsequence

  property p_resp_pulse;
    @(posedge ref_clk) disable iff (!rst_b)
      s_lone_nop |=> !status_resp_valid_r;
  endproperty
  a_resp_pulse: assert property (p_resp_pulse)
    else $error("nop response held too long");

  property p_serial_set;
    @(posedge ref_clk) disable iff (!rst_b)
      (|serial_fault_bits) |=> flags[`ASR_BIT_SERIAL];
  endproperty
  a_serial_set: assert property (p_serial_set)
    else $error("serial summary not set");

  property p_input_set;
    @(posedge ref_clk) disable iff (!rst_b)
      inp_set |=> flags[`ASR_BIT_INPUT_SUM];
  endproperty
  a_input_set: assert property (p_input_set)
    else $error("input summary not set");

  property p_input_clr;
    @(posedge ref_clk) disable iff (!rst_b)
      inp_clr && !inp_set |=> !flags[`ASR_BIT_INPUT_SUM];
  endproperty
  a_input_clr: assert property (p_input_clr)
    else $error("input summary not cleared after both reads");

  property p_wdog_clr;
    @(posedge ref_clk) disable iff (!rst_b)
      gen_xfer && !watchdog_expired |=> !flags[`ASR_BIT_WATCHDOG];
  endproperty
  a_wdog_clr: assert property (p_wdog_clr)
    else $error("watchdog flag not cleared by transfer");

  property p_overrun_set;
    @(posedge ref_clk) disable iff (!rst_b)
      data_overrun |=> flags[`ASR_BIT_OVERRUN];
  endproperty
  a_overrun_set: assert property (p_overrun_set)
    else $error("overrun flag not set");

  property p_check_set;
    @(posedge ref_clk) disable iff (!rst_b)
      input_check_error |=> flags[`ASR_BIT_INPUT_CHECK];
  endproperty
  a_check_set: assert property (p_check_set)
    else $error("input check flag not set");

  property p_check_clr;
    @(posedge ref_clk) disable iff (!rst_b)
      ser_xfer && !input_check_error |=> !flags[`ASR_BIT_INPUT_CHECK];
  endproperty
  a_check_clr: assert property (p_check_clr)
    else $error("input check flag not cleared by serial transfer");

  property p_pos_read;
    @(posedge ref_clk) disable iff (!rst_b)
      rd_stb && rd_addr == `ASR_ADDR_POS_FAULT |=> rd_data_r[7:4] == 4'h0 &&
        rd_data_r[3:0] == ($past(pos_over_threshold, 2) & ch_mask);
  endproperty
  a_pos_read: assert property (p_pos_read)
    else $error("positive fault byte wrong");

  property p_neg_read;
    @(posedge ref_clk) disable iff (!rst_b)
      rd_stb && rd_addr == `ASR_ADDR_NEG_FAULT |=> rd_data_r[7:4] == 4'h0 &&
        rd_data_r[3:0] == ($past(neg_over_threshold, 2) & ch_mask);
  endproperty
  a_neg_read: assert property (p_neg_read)
    else $error("negative fault byte wrong");

endmodule : asr_status_regs

// *** hw/asr_consts.svh ***
`ifndef ASR_CONSTS_SVH
`define ASR_CONSTS_SVH

`define ASR_ADDR_ID_HIGH   5'h00
`define ASR_ADDR_ID_LOW    5'h01
`define ASR_ADDR_GEN_FAULT 5'h02
`define ASR_ADDR_POS_FAULT 5'h03
`define ASR_ADDR_NEG_FAULT 5'h04
`define ASR_ADDR_SER_FAULT 5'h05

`define ASR_BIT_INVALID_CMD  6
`define ASR_BIT_SERIAL       5
`define ASR_BIT_INPUT_SUM    4
`define ASR_BIT_WATCHDOG     3
`define ASR_BIT_RESYNC       2
`define ASR_BIT_OVERRUN      1
`define ASR_BIT_INPUT_CHECK  0

`define ASR_CH_CODE_TWO   4'h2
`define ASR_CH_CODE_FOUR  4'h4
`define ASR_REV_CODE      4'ha
`define ASR_RESET_BYTE    8'h00

`endif

// *** hw/asr_pkg.sv ***
package asr_pkg;
  typedef enum logic [1:0] {
    ASR_CMD_OTHER  = 2'b00,
    ASR_CMD_NOP    = 2'b01,
    ASR_CMD_LOCKOK = 2'b10,
    ASR_CMD_BAD    = 2'b11
  } asr_cmd_t;
endpackage : asr_pkg

// *** hw/asr_flag.sv ***
// Sticky flag: set wins over clear, re-set while cause persists
module asr_flag (
  input  wire logic ref_clk,
  input  wire logic rst_b,
  input  wire logic set_in,
  input  wire logic clr_in,
  output logic      flag_r
);
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      flag_r <= 1'b0;
    end else if (set_in) begin
      flag_r <= 1'b1;
    end else if (clr_in) begin
      flag_r <= 1'b0;
    end
  end
endmodule : asr_flag

// *** testbench/asr_host_model.sv ***
// ----------------------------------------
// Host side: issues reads, writes, commands
// ----------------------------------------
module asr_host_model (
  input  wire logic        ref_clk,
  output logic             rd_stb,
  output logic       [4:0] rd_addr,
  output logic             wr_stb,
  output logic       [4:0] wr_addr,
  output logic       [7:0] wr_data,
  output logic             cmd_stb,
  output asr_pkg::asr_cmd_t cmd_kind,
  input  wire logic  [7:0] rd_data_r,
  input  wire logic        rd_valid_r,
  input  wire logic  [7:0] status_resp_r,
  input  wire logic        status_resp_valid_r
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rd_stb   = 1'b0;
    rd_addr  = 5'h00;
    wr_stb   = 1'b0;
    wr_addr  = 5'h00;
    wr_data  = 8'h00;
    cmd_stb  = 1'b0;
    cmd_kind = asr_pkg::ASR_CMD_OTHER;
  end
  // Released read address and write data show inverted values; write address and command kind hold
  task automatic rd(input logic [4:0] a, output logic [8:0] r);
    @(posedge ref_clk);
    rd_stb  <= 1'b1;
    rd_addr <= a;
    @(posedge ref_clk);
    rd_stb  <= 1'b0;
    rd_addr <= ~a;
    #1;
    r = {rd_valid_r, rd_data_r};
  endtask : rd
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    wr_stb  <= 1'b1;
    wr_addr <= a;
    wr_data <= d;
    @(posedge ref_clk);
    wr_stb  <= 1'b0;
    wr_data <= ~d;
  endtask : wr
  task automatic cmd(input asr_pkg::asr_cmd_t k, output logic [8:0] r);
    @(posedge ref_clk);
    cmd_stb  <= 1'b1;
    cmd_kind <= k;
    @(posedge ref_clk);
    cmd_stb  <= 1'b0;
    #1;
    r = {status_resp_valid_r, status_resp_r};
  endtask : cmd
endmodule : asr_host_model

// *** testbench/tb.sv ***
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] REV = 4'h5;  // Arbitrary value
  logic       ref_clk = 1'b0;
  logic       rst_b   = 1'b0;
  logic       locked  = 1'b0;
  logic [2:0] ser     = 3'h0;
  logic [3:0] ev      = 4'h0;
  logic [3:0] pos     = 4'h0;
  logic [3:0] neg     = 4'h0;
  int         error_cnt, comparisons, cyc;
  logic [8:0] r;
  logic       rs, ws, cs, rv, sv, rv2;
  logic [4:0] ra, wa;
  logic [7:0] wd, rdat, sdat, rdat2;
  asr_pkg::asr_cmd_t ck;
  always #10 ref_clk = ~ref_clk;
  asr_host_model u_host (.ref_clk(ref_clk), .rd_stb(rs), .rd_addr(ra),
    .wr_stb(ws), .wr_addr(wa), .wr_data(wd), .cmd_stb(cs), .cmd_kind(ck),
    .rd_data_r(rdat), .rd_valid_r(rv), .status_resp_r(sdat),
    .status_resp_valid_r(sv));
  asr_status_regs #(.NUM_CH(4), .REV_CODE(REV)) u_dut (.ref_clk(ref_clk),
    .rst_b(rst_b), .rd_stb(rs), .rd_addr(ra), .wr_stb(ws), .wr_addr(wa),
    .wr_data(wd), .cmd_stb(cs), .cmd_kind(ck), .if_locked(locked),
    .serial_fault_bits(ser), .watchdog_expired(ev[3]),
    .resync_event(ev[2]), .data_overrun(ev[1]), .input_check_error(ev[0]),
    .pos_over_threshold(pos), .neg_over_threshold(neg), .rd_data_r(rdat),
    .rd_valid_r(rv), .status_resp_r(sdat), .status_resp_valid_r(sv));
  // Two-channel variant on the same stimulus
  asr_status_regs #(.NUM_CH(2), .REV_CODE(REV)) u_dut_two (
    .ref_clk(ref_clk), .rst_b(rst_b), .rd_stb(rs), .rd_addr(ra),
    .wr_stb(ws), .wr_addr(wa), .wr_data(wd), .cmd_stb(cs), .cmd_kind(ck),
    .if_locked(locked), .serial_fault_bits(ser), .watchdog_expired(ev[3]),
    .resync_event(ev[2]), .data_overrun(ev[1]), .input_check_error(ev[0]),
    .pos_over_threshold(pos), .neg_over_threshold(neg), .rd_data_r(rdat2),
    .rd_valid_r(rv2), .status_resp_r(), .status_resp_valid_r());
  // ----------------------------------------
  // Shared checks
  // ----------------------------------------
  task automatic check(input string n, input logic [8:0] e,
                       input logic [8:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : check
  task automatic rdc(input logic [4:0] a, input logic [7:0] e,
                     input string n);
    u_host.rd(a, r);
    check(n, {1'b1, e}, r);
  endtask : rdc
  task automatic cmc(input logic [7:0] e, input string n);
    u_host.cmd(asr_pkg::ASR_CMD_NOP, r);
    check(n, {1'b1, e}, r);
  endtask : cmc
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_map;
    rdc(5'h00, {REV, 4'h4}, "id high");
    rdc(5'h01, 8'h00, "id low");
    for (int a = 2; a < 5; a++) begin
      rdc(a[4:0], 8'h00, "status reset");
    end
    rdc(5'h1f, 8'h00, "unmapped");
  endtask : t_map
  task automatic t_write;
    // Writes are attempts only; contents must not move
    for (int a = 0; a < 5; a++) begin
      u_host.wr(a[4:0], 8'hff);
    end
    rdc(5'h00, {REV, 4'h4}, "id after write");
    rdc(5'h02, 8'h00, "gen after write");
  endtask : t_write
  task automatic t_cmds;
    cmc(8'h00, "nop clean");
    u_host.cmd(asr_pkg::ASR_CMD_BAD, r);
    cmc(8'h40, "bad cmd");
    cmc(8'h00, "bad cleared");
    @(posedge ref_clk);
    locked <= 1'b1;
    u_host.cmd(asr_pkg::ASR_CMD_OTHER, r);
    cmc(8'h40, "locked other");
    u_host.cmd(asr_pkg::ASR_CMD_LOCKOK, r);
    cmc(8'h00, "locked exempt");
    @(posedge ref_clk);
    locked <= 1'b0;
    u_host.cmd(asr_pkg::ASR_CMD_OTHER, r);
    cmc(8'h00, "unlocked other");
  endtask : t_cmds
  task automatic t_events;
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      ev <= 4'h1 << i;
      @(posedge ref_clk);
      ev <= 4'h0;
      // Check flag stays up until the serial register is transferred
      cmc((8'h01 << i) | 8'h01, "event set");
      cmc(8'h01, "event after nop");
    end
    u_host.rd(5'h05, r);
    cmc(8'h00, "check cleared");
  endtask : t_events
  task automatic t_serial;
    @(posedge ref_clk);
    ser <= 3'h2;
    repeat (2) @(posedge ref_clk);
    cmc(8'h20, "serial set");
    @(posedge ref_clk);
    ser <= 3'h0;
    cmc(8'h20, "serial sticky");
    u_host.rd(5'h05, r);
    cmc(8'h00, "serial cleared");
  endtask : t_serial
  task automatic t_input;
    @(posedge ref_clk);
    pos <= 4'h9;
    neg <= 4'h6;
    repeat (2) @(posedge ref_clk);
    rdc(5'h03, 8'h09, "pos flags");
    rdc(5'h04, 8'h06, "neg flags");
    cmc(8'h10, "input summary");
    @(posedge ref_clk);
    pos <= 4'h0;
    neg <= 4'h0;
    repeat (2) @(posedge ref_clk);
    rdc(5'h03, 8'h00, "pos low");
    rdc(5'h04, 8'h00, "neg low");
    cmc(8'h00, "summary cleared");
  endtask : t_input
  task automatic t_narrow;
    // Upper channels exist only in the wide variant
    @(posedge ref_clk);
    pos <= 4'hf;
    neg <= 4'hf;
    repeat (2) @(posedge ref_clk);
    u_host.rd(5'h00, r);
    check("narrow id", {1'b1, REV, 4'h2}, {rv2, rdat2});
    u_host.rd(5'h03, r);
    check("wide pos", 9'h10f, r);
    check("narrow pos", 9'h103, {rv2, rdat2});
    u_host.rd(5'h04, r);
    check("wide neg", 9'h10f, r);
    check("narrow neg", 9'h103, {rv2, rdat2});
  endtask : t_narrow
  task automatic give_verdict;
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict
  // Ceiling well above the roughly 130 cycles the run needs
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      give_verdict();
    end
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_map();
    t_write();
    t_cmds();
    t_events();
    t_serial();
    t_input();
    t_narrow();
    give_verdict();
  end
endmodule : tb
